// [sep_pkg.sv]
/*
  Shared constants for the serial EEPROM command and protection front end:
  opcodes, status bit positions, guard codes, geometry, sampler indices,
  session states and program cycle timing.
  Assumes a 200 MHz core clock.
*/
package sep_pkg;

  // opcodes
  localparam logic [7:0] OP_WR_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WR_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // status_control bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_LATCH = 1;
  localparam int SB_BG_LO = 2;
  localparam int SB_BG_HI = 3;
  localparam int SB_ID_LOCK = 4;
  localparam int SB_ID_SEL = 6;
  localparam int SB_PIN_EN = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // block guard codes
  localparam logic [1:0] BG_NONE = 2'h0;
  localparam logic [1:0] BG_QUARTER = 2'h1;
  localparam logic [1:0] BG_HALF = 2'h2;
  localparam logic [1:0] BG_FULL = 2'h3;
  localparam logic [1:0] QTR_TOP = 2'h3;

  // geometry
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int ARRAY_AW = 14;
  localparam int ARRAY_BYTES = 16384;
  localparam int ID_AW = 6;
  localparam int ID_BYTES = 64;
  localparam logic [ARRAY_AW-1:0] ARR_STEP = 14'h0001;
  localparam logic [ID_AW-1:0] PAGE_STEP = 6'h01;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // input sampler lanes
  localparam int SY_SCK = 0;
  localparam int SY_CS = 1;
  localparam int SY_SI = 2;
  localparam int SY_PAUSE = 3;
  localparam int SY_WP = 4;
  localparam int SY_N = 5;
  // pin levels the samplers hold in reset, so no false edge follows it
  localparam logic [SY_N-1:0] SYNC_IDLE = 5'h1a;

  // program cycle timing
  localparam int PROG_TIME_MS = 4;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * CLK_FREQ_KHZ;
  localparam int PROG_CNT_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_SREAD = 3'b101,
    ST_SWRITE = 3'b110,
    ST_IGNORE = 3'b111
  } sep_state_e;

endpackage : sep_pkg

// [sep_prog_if.sv]
/*
  Carrier between the session logic and the program cycle timer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface sep_prog_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface : sep_prog_if

// [sep_prog_timer.sv]
/*
  Self-timed program cycle timer: busy for a fixed number of core cycles
  after a start pulse.
  Assumes start is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
module sep_prog_timer
  import sep_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // control carrier
  sep_prog_if.timer prog
);

  logic [PROG_CNT_W-1:0] cnt_ff;
  logic busy_ff;

  assign prog.busy = busy_ff;

  // a start while busy is dropped; the session blocks it anyway
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
    end
    else if (prog.start && !busy_ff)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= PROG_CNT_W'(CYCLES - 1);
    end
    else if (busy_ff)
    begin
      if (cnt_ff == '0)
        busy_ff <= 1'b0;
      else
        cnt_ff <= cnt_ff - PROG_CNT_W'(1);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_start_busy: assert property (prog.start && !busy_ff |=> busy_ff && cnt_ff == PROG_CNT_W'(CYCLES - 1)) else $error("program cycle did not start");
  a_cycle_bound: assert property ($fell(busy_ff) |-> $past(cnt_ff) == '0) else $error("program cycle ended early");

endmodule : sep_prog_timer

// [sep_spi_eeprom.sv]
/*
  Serial-peripheral slave front end of a 16K x 8 serial EEPROM: samples the
  pins, frames sessions, decodes opcodes, holds status_control, checks write
  permission and hands program cycles to the timer.
  Assumes all pins are asynchronous to core_clk_in and the serial clock is
  slow enough (>= 8 core cycles per period) for oversampling.
*/
`timescale 1ns/1ps
module sep_spi_eeprom
  import sep_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // serial link pins
  input wire logic spi_clk_in,
  input wire logic chip_sel_n_in,
  input wire logic ser_data_in,
  input wire logic transfer_pause_n_in,
  input wire logic write_guard_n_in,
  // serial output pin
  output logic ser_data_out,
  output logic ser_data_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [SY_N-1:0] pins;
  logic [SY_N-1:0] sync1_ff;
  logic [SY_N-1:0] sync2_ff;
  logic sck_prev_ff;
  logic cs_prev_ff;

  assign pins = {write_guard_n_in, transfer_pause_n_in, ser_data_in, chip_sel_n_in, spi_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++)
    begin : g_sync
      always_ff @(posedge core_clk_in)
      begin
        if (srst_in)
        begin
          sync1_ff[gi] <= SYNC_IDLE[gi];
          sync2_ff[gi] <= SYNC_IDLE[gi];
        end
        else
        begin
          sync1_ff[gi] <= pins[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // reset parks chip select high so a held-low pin still gives a clean fall
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end
    else
    begin
      sck_prev_ff <= sync2_ff[SY_SCK];
      cs_prev_ff <= sync2_ff[SY_CS];
    end
  end

  logic cs_n_s;
  logic si_s;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign cs_n_s = sync2_ff[SY_CS];
  assign si_s = sync2_ff[SY_SI];
  // pause freezes the bit engine; host holds the clock still at both transitions, low in mode 0 and high in mode 3
  assign active = !cs_n_s && sync2_ff[SY_PAUSE];
  assign sck_rise = active && sync2_ff[SY_SCK] && !sck_prev_ff;
  assign sck_fall = active && !sync2_ff[SY_SCK] && sck_prev_ff;
  assign cs_fall = !cs_n_s && cs_prev_ff;
  assign cs_rise = cs_n_s && !cs_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // status, permission and timer hookup

  sep_prog_if prog_bus ();

  sep_prog_timer #(.CYCLES(PROG_CYCLES_P)) u_timer (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .prog(prog_bus.timer)
  );

  logic pin_en_ff;
  logic id_sel_ff;
  logic id_lock_ff;
  logic [1:0] bg_ff;
  logic latch_ff;
  logic busy_prev_ff;
  logic busy;
  logic [BYTE_W-1:0] status_byte;
  logic hw_guard;

  assign busy = prog_bus.busy;
  assign status_byte = {pin_en_ff, id_sel_ff, 1'b0, id_lock_ff, bg_ff, latch_ff, busy};
  assign hw_guard = pin_en_ff && !sync2_ff[SY_WP];

  function automatic logic guarded(input logic [1:0] bg, input logic [ARRAY_AW-1:0] a);
    logic g;
    g = 1'b0;
    case (bg)
      BG_NONE: g = 1'b0;
      BG_QUARTER: g = (a[ARRAY_AW-1 -: 2] == QTR_TOP);
      BG_HALF: g = a[ARRAY_AW-1];
      default: g = 1'b1;
    endcase
    return g;
  endfunction : guarded

  ////////////////////////////////////////////////////////////////////////////
  // session engine

  sep_state_e state_ff;
  logic [2:0] bit_cnt_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [BYTE_W-1:0] cmd_ff;
  logic cmd_ok_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic addr_hi_done_ff;
  logic [BYTE_W-1:0] swr_data_ff;
  logic swr_full_ff;
  logic wrote_ff;
  logic load_ff;
  logic [BYTE_W-1:0] rx_byte;
  logic byte_done;
  logic wr_allow;
  logic mem_we;

  assign rx_byte = {shift_ff[BYTE_W-2:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_ff == BIT_LAST);
  // the identification page is never guarded by quarter or half codes
  assign wr_allow = latch_ff && (id_sel_ff
                    ? (!id_lock_ff && !guarded(bg_ff, {{(ARRAY_AW-ID_AW){1'b0}}, addr_ff[ID_AW-1:0]}))
                    : !guarded(bg_ff, addr_ff[ARRAY_AW-1:0]));
  assign mem_we = byte_done && (state_ff == ST_WDATA) && wr_allow;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= BIT_FIRST;
      shift_ff <= '0;
      cmd_ff <= '0;
      cmd_ok_ff <= 1'b0;
      addr_hi_done_ff <= 1'b0;
    end
    else if (cs_n_s)
    begin
      state_ff <= ST_IDLE;
    end
    else if (cs_fall)
    begin
      state_ff <= ST_CMD;
      bit_cnt_ff <= BIT_FIRST;
      shift_ff <= '0;
      cmd_ok_ff <= 1'b0;
      addr_hi_done_ff <= 1'b0;
    end
    else if (sck_rise)
    begin
      shift_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      case (state_ff)
        ST_CMD:
        begin
          if (byte_done)
          begin
            cmd_ff <= rx_byte;
            cmd_ok_ff <= 1'b1;
            if (busy && rx_byte != OP_STATUS_READ)
            begin
              state_ff <= ST_IGNORE;
              cmd_ok_ff <= 1'b0;
            end
            else if (rx_byte == OP_WR_LATCH_SET || rx_byte == OP_WR_LATCH_CLR)
              state_ff <= ST_IGNORE;
            else if (rx_byte == OP_STATUS_READ)
              state_ff <= ST_SREAD;
            else if (rx_byte == OP_STATUS_WRITE)
              state_ff <= ST_SWRITE;
            else if (rx_byte == OP_MEM_READ || rx_byte == OP_MEM_WRITE)
              state_ff <= ST_ADDR;
            else
            begin
              state_ff <= ST_IGNORE;
              cmd_ok_ff <= 1'b0;
            end
          end
        end
        ST_ADDR:
        begin
          if (byte_done)
          begin
            addr_hi_done_ff <= 1'b1;
            if (addr_hi_done_ff)
              state_ff <= (cmd_ff == OP_MEM_READ) ? ST_RDATA : ST_WDATA;
          end
        end
        ST_SWRITE:
        begin
          if (byte_done)
            state_ff <= ST_IGNORE;
        end
        default:
        begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // address pointer and write bookkeeping
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      addr_ff <= '0;
      swr_data_ff <= '0;
      swr_full_ff <= 1'b0;
      wrote_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      swr_full_ff <= 1'b0;
      wrote_ff <= 1'b0;
    end
    else if (sck_rise)
    begin
      if (state_ff == ST_ADDR)
        addr_ff <= {addr_ff[ADDR_W-2:0], si_s};
      if (byte_done && state_ff == ST_SWRITE)
      begin
        swr_data_ff <= rx_byte;
        swr_full_ff <= 1'b1;
      end
      // page writes wrap inside the page, reads run through the whole space
      if (byte_done && state_ff == ST_WDATA)
      begin
        addr_ff[ID_AW-1:0] <= addr_ff[ID_AW-1:0] + PAGE_STEP;
        if (wr_allow)
          wrote_ff <= 1'b1;
      end
      if (byte_done && state_ff == ST_RDATA)
      begin
        if (id_sel_ff)
          addr_ff[ID_AW-1:0] <= addr_ff[ID_AW-1:0] + PAGE_STEP;
        else
          addr_ff[ARRAY_AW-1:0] <= addr_ff[ARRAY_AW-1:0] + ARR_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [BYTE_W-1:0] array_ff [0:ARRAY_BYTES-1];
  logic [BYTE_W-1:0] id_page_ff [0:ID_BYTES-1];
  logic [BYTE_W-1:0] rd_byte;

  // bytes land at once; reads stay blocked until the program cycle ends
  always_ff @(posedge core_clk_in)
  begin
    if (mem_we)
    begin
      if (id_sel_ff)
        id_page_ff[addr_ff[ID_AW-1:0]] <= rx_byte;
      else
        array_ff[addr_ff[ARRAY_AW-1:0]] <= rx_byte;
    end
  end

  assign rd_byte = id_sel_ff ? id_page_ff[addr_ff[ID_AW-1:0]]
                             : array_ff[addr_ff[ARRAY_AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // status register and program start

  logic end_ok;
  logic swr_ok;
  logic prog_done;
  logic prog_start;

  assign end_ok = cs_rise && cmd_ok_ff;
  assign swr_ok = (cmd_ff == OP_STATUS_WRITE) && swr_full_ff && latch_ff && !hw_guard;
  assign prog_done = busy_prev_ff && !busy;
  assign prog_start = end_ok && (swr_ok || (cmd_ff == OP_MEM_WRITE && wrote_ff));
  assign prog_bus.start = prog_start;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      busy_prev_ff <= 1'b0;
    else
      busy_prev_ff <= busy;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      {pin_en_ff, id_sel_ff, id_lock_ff, bg_ff, latch_ff} <=
        {STATUS_RESET[SB_PIN_EN], STATUS_RESET[SB_ID_SEL], STATUS_RESET[SB_ID_LOCK],
         STATUS_RESET[SB_BG_HI:SB_BG_LO], STATUS_RESET[SB_LATCH]};
    end
    else
    begin
      if (end_ok && cmd_ff == OP_WR_LATCH_SET)
        latch_ff <= 1'b1;
      if (end_ok && cmd_ff == OP_WR_LATCH_CLR)
        latch_ff <= 1'b0;
      if (end_ok && swr_ok)
      begin
        pin_en_ff <= swr_data_ff[SB_PIN_EN];
        bg_ff <= swr_data_ff[SB_BG_HI:SB_BG_LO];
        if (!(swr_data_ff[SB_ID_SEL] && swr_data_ff[SB_ID_LOCK]))
        begin
          id_sel_ff <= swr_data_ff[SB_ID_SEL];
          id_lock_ff <= id_lock_ff | swr_data_ff[SB_ID_LOCK];
        end
      end
      if (end_ok && (cmd_ff == OP_MEM_READ || cmd_ff == OP_MEM_WRITE))
        id_sel_ff <= 1'b0;
      if (prog_done)
        latch_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output

  logic [BYTE_W-1:0] tx_ff;
  logic so_ff;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      load_ff <= 1'b0;
    else
      load_ff <= byte_done && ((state_ff == ST_ADDR && addr_hi_done_ff && cmd_ff == OP_MEM_READ)
                 || state_ff == ST_RDATA || state_ff == ST_CMD || state_ff == ST_SREAD);
  end

  // the load lands one core cycle after the rise, well before the next fall
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      tx_ff <= '0;
      so_ff <= 1'b0;
    end
    else if (load_ff)
      tx_ff <= (state_ff == ST_SREAD) ? status_byte : rd_byte;
    else if (sck_fall)
    begin
      so_ff <= tx_ff[BYTE_W-1];
      tx_ff <= {tx_ff[BYTE_W-2:0], 1'b0};
    end
  end

  assign ser_data_out = so_ff;
  assign ser_data_oe_out = active && (state_ff == ST_RDATA || state_ff == ST_SREAD);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_deselect_hiz: assert property (cs_n_s |-> !ser_data_oe_out) else $error("output driven while deselected");
  a_out_on_fall: assert property ($changed(so_ff) |-> $past(sck_fall)) else $error("output changed off a falling edge");
  a_in_on_rise: assert property ($changed(bit_cnt_ff) && !$past(cs_fall) |-> $past(sck_rise)) else $error("input sampled off a rising edge");
  a_ignore_holds: assert property (state_ff == ST_IGNORE && !cs_n_s |=> state_ff == ST_IGNORE || cs_n_s) else $error("ignored session resumed");
  a_busy_filter: assert property (busy && byte_done && state_ff == ST_CMD && rx_byte != OP_STATUS_READ |=> state_ff == ST_IGNORE && !cmd_ok_ff) else $error("command taken while busy");
  a_latch_done: assert property (prog_done |=> !latch_ff) else $error("write latch kept after program cycle");
  a_bit5_zero: assert property (!status_byte[5] && status_byte[SB_BUSY] == busy) else $error("status layout wrong");
  a_guard_write: assert property (mem_we |-> latch_ff && !(id_sel_ff && id_lock_ff) && !(!id_sel_ff && guarded(bg_ff, addr_ff[ARRAY_AW-1:0]))) else $error("guarded location written");
  a_both_bits: assert property (end_ok && swr_ok && swr_data_ff[SB_ID_SEL] && swr_data_ff[SB_ID_LOCK] |=> $stable(id_sel_ff) && $stable(id_lock_ff)) else $error("select and lock set together");
  a_hw_guard: assert property (end_ok && cmd_ff == OP_STATUS_WRITE && hw_guard |=> $stable(bg_ff) && $stable(pin_en_ff)) else $error("status written under pin guard");
  a_start_busy: assert property (prog_start && !busy |=> busy) else $error("program cycle not started");

  c_status_read: cover property (state_ff == ST_SREAD && sck_fall);
  c_status_write: cover property (end_ok && swr_ok);
  c_page_write: cover property (prog_start && cmd_ff == OP_MEM_WRITE);
  c_mem_read: cover property (state_ff == ST_RDATA && load_ff);

endmodule : sep_spi_eeprom

// [sep_host_model.sv]
/*
  Host serial master model: frames sessions and shifts bytes in mode 0 or 3.
  Assumes the device answers within one serial clock low phase.
*/
`timescale 1ns/1ps
module sep_host_model
(
  // pins toward the device
  output logic spi_clk_out,
  output logic chip_sel_n_out,
  output logic ser_data_out,
  output logic transfer_pause_n_out,
  // device output
  input wire logic ser_data_in,
  input wire logic ser_data_oe_in,
  // clock idles high when set
  input wire logic spi_mode3_in
);
  logic last_bit;
  logic pause_oe;

  initial
  begin
    spi_clk_out = 1'b0;
    chip_sel_n_out = 1'b1;
    ser_data_out = 1'b0;
    transfer_pause_n_out = 1'b1;
    last_bit = 1'b0;
    pause_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // a released output reads as the inverse of the last bit, so it never matches by luck
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (spi_mode3_in)
        #24 spi_clk_out = 1'b0;
      ser_data_out = tx[i];
      #24 spi_clk_out = 1'b1;
      rx[i] = ser_data_oe_in ? ser_data_in : ~last_bit;
      last_bit = rx[i];
      if (!spi_mode3_in)
        #24 spi_clk_out = 1'b0;
    end
  endtask : xbyte

  // clock stands at its mode's idle level between frames; pause only moves while it rests after a byte, low in mode 0 and high in mode 3
  task automatic frame(input logic [7:0] op, input logic [15:0] adr, input logic [7:0] dat,
    input int n, input logic pz, output logic [7:0] rx);
    spi_clk_out = spi_mode3_in;
    #30 chip_sel_n_out = 1'b0;
    #30 xbyte(op, rx);
    if (pz)
    begin
      #40 transfer_pause_n_out = 1'b0;
      #40 pause_oe = ser_data_oe_in;
      transfer_pause_n_out = 1'b1;
      #40;
    end
    if (n > 2)
    begin
      xbyte(adr[15:8], rx);
      xbyte(adr[7:0], rx);
    end
    if (n > 1)
      xbyte(dat, rx);
    #30 chip_sel_n_out = 1'b1;
    #60;
  endtask : frame
endmodule : sep_host_model

// [sep_spi_eeprom_tb.sv]
/*
  Self-checking bench for the serial EEPROM front end, driven by the host model.
  Assumes a shortened program cycle of 400 core cycles.
*/
`timescale 1ns/1ps
module sep_spi_eeprom_tb;
  import sep_pkg::*;
  localparam int unsigned PROG_N = 400;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic write_guard_n_in = 1'b1;
  logic sck;
  logic csn;
  logic si;
  logic pausen;
  logic so;
  logic oe;
  logic mode3 = 1'b0;
  int oe_hits = 0;
  logic [7:0] rx;
  int err_count = 0;
  int tests_run = 0;

  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
    if (oe === 1'b1)
      oe_hits <= oe_hits + 1;

  sep_spi_eeprom #(.PROG_CYCLES_P(PROG_N)) i_sep_spi_eeprom (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .spi_clk_in(sck),
    .chip_sel_n_in(csn), .ser_data_in(si), .transfer_pause_n_in(pausen),
    .write_guard_n_in(write_guard_n_in), .ser_data_out(so), .ser_data_oe_out(oe));
  sep_host_model i_sep_host_model (
    .spi_clk_out(sck), .chip_sel_n_out(csn), .ser_data_out(si),
    .transfer_pause_n_out(pausen), .ser_data_in(so), .ser_data_oe_in(oe),
    .spi_mode3_in(mode3));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic fr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
    input int n);
    i_sep_host_model.frame(op, a, d, n, 1'b0, rx);
  endtask : fr

  task automatic status_read_cmd();
    fr(OP_STATUS_READ, 16'h0000, 8'h00, 2);
  endtask : status_read_cmd

  task automatic wr_latch_set_cmd();
    fr(OP_WR_LATCH_SET, 16'h0000, 8'h00, 1);
  endtask : wr_latch_set_cmd

  task automatic status_write_cmd(input logic [7:0] v);
    wr_latch_set_cmd();
    fr(OP_STATUS_WRITE, 16'h0000, v, 2);
  endtask : status_write_cmd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    fr(OP_MEM_WRITE, a, d, 4);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    fr(OP_MEM_READ, a, 8'h00, 4);
  endtask : rd

  // first poll tells whether a cycle started; the rest wait it out, bounded
  task automatic prog(input logic exp);
    int k;
    k = 0;
    status_read_cmd();
    check("busy", {7'h00, rx[SB_BUSY]}, {7'h00, exp});
    while (rx[SB_BUSY] !== 1'b0)
    begin
      k++;
      if (k > 4)
      begin
        err_count++;
        $display("ERROR busy expected 0 seen 1");
        final_report();
      end
      status_read_cmd();
    end
  endtask : prog

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    status_read_cmd();
    check("status reset", rx, STATUS_RESET);
    wr_latch_set_cmd();
    status_read_cmd();
    check("latch set", rx, 8'h02);
    fr(OP_WR_LATCH_CLR, 16'h0000, 8'h00, 1);
    status_read_cmd();
    check("latch clear", rx, 8'h00);
  endtask : t_latch

  // later bytes look like real commands and must still be ignored
  task automatic t_unknown();
    int h;
    h = oe_hits;
    fr(8'hff, 16'h0506, 8'h06, 4);
    check("oe after unknown", (oe_hits == h) ? 8'h00 : 8'h01, 8'h00);
    status_read_cmd();
    check("unknown no effect", rx, 8'h00);
  endtask : t_unknown

  task automatic t_array();
    wr_latch_set_cmd();
    wr(16'h3000, 8'h22);
    // a status write sent while busy must leave the guard bits alone
    fr(OP_STATUS_WRITE, 16'h0000, 8'h0c, 2);
    prog(1'b1);
    status_read_cmd();
    check("latch after program", rx, 8'h00);
    rd(16'h3000);
    check("array read", rx, 8'h22);
  endtask : t_array

  task automatic t_guard();
    status_write_cmd(8'h57);
    prog(1'b1);
    status_read_cmd();
    check("status write", rx, 8'h04);
    wr_latch_set_cmd();
    wr(16'h3000, 8'h33);
    prog(1'b0);
    wr_latch_set_cmd();
    wr(16'h2fff, 8'h44);
    prog(1'b1);
    wr(16'h2fff, 8'h55);
    prog(1'b0);
    for (int g = 2; g < 4; g++)
    begin
      status_write_cmd({4'h0, g[1:0], 2'h0});
      prog(1'b1);
      wr_latch_set_cmd();
      wr(16'h2fff, 8'h66);
      prog(1'b0);
    end
    rd(16'h2fff);
    check("unguarded kept", rx, 8'h44);
    rd(16'h3000);
    check("guarded kept", rx, 8'h22);
  endtask : t_guard

  task automatic t_idpage();
    status_write_cmd(8'h44);
    prog(1'b1);
    wr_latch_set_cmd();
    wr(16'h0005, 8'h77);
    prog(1'b1);
    status_read_cmd();
    check("select cleared", rx, 8'h04);
    status_write_cmd(8'h44);
    prog(1'b1);
    rd(16'h0005);
    check("id page read", rx, 8'h77);
    status_write_cmd(8'h14);
    prog(1'b1);
    status_read_cmd();
    check("lock set", rx, 8'h14);
    status_write_cmd(8'h44);
    prog(1'b1);
    wr_latch_set_cmd();
    wr(16'h0005, 8'h88);
    prog(1'b0);
    status_write_cmd(8'h44);
    prog(1'b1);
    rd(16'h0005);
    check("locked page kept", rx, 8'h77);
  endtask : t_idpage

  task automatic t_pin();
    status_write_cmd(8'h84);
    prog(1'b1);
    @(posedge core_clk_in);
    #1 write_guard_n_in = 1'b0;
    status_write_cmd(8'h00);
    prog(1'b0);
    status_read_cmd();
    check("status held", rx & 8'hfd, 8'h94);
    wr_latch_set_cmd();
    wr(16'h2ffe, 8'h99);
    prog(1'b1);
    rd(16'h2ffe);
    check("pin unguarded", rx, 8'h99);
    @(posedge core_clk_in);
    #1 write_guard_n_in = 1'b1;
    status_write_cmd(8'h00);
    prog(1'b1);
    status_read_cmd();
    check("pin released", rx, 8'h10);
  endtask : t_pin

  task automatic t_mode3();
    mode3 = 1'b1;
    status_read_cmd();
    check("status mode 3", rx, 8'h10);
    rd(16'h2ffe);
    check("read mode 3", rx, 8'h99);
    mode3 = 1'b0;
  endtask : t_mode3

  task automatic t_pause();
    i_sep_host_model.frame(OP_STATUS_READ, 16'h0000, 8'h00, 2, 1'b1, rx);
    check("oe in pause", {7'h00, i_sep_host_model.pause_oe}, 8'h00);
    check("status after pause", rx, 8'h10);
    check("oe deselected", {7'h00, oe}, 8'h00);
  endtask : t_pause

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge core_clk_in);
    #1 srst_in = 1'b0;
    // host settles before its first command
    repeat (4) @(posedge core_clk_in);
    #1;
    t_latch();
    t_unknown();
    t_array();
    t_guard();
    t_idpage();
    t_pin();
    t_mode3();
    t_pause();
    final_report();
  end
endmodule : sep_spi_eeprom_tb
